// File: src/bdu_pkg.sv
package bdu_pkg;
   localparam int BDU_SLOTS = 4;
   // Register select codes on the move port
   localparam logic [2:0] BDU_SEL_SLOT0 = 3'h0;
   localparam logic [2:0] BDU_SEL_SLOT1 = 3'h1;
   localparam logic [2:0] BDU_SEL_SLOT2 = 3'h2;
   localparam logic [2:0] BDU_SEL_SLOT3 = 3'h3;
   localparam logic [2:0] BDU_SEL_STATUS = 3'h6;
   localparam logic [2:0] BDU_SEL_CONTROL = 3'h7;
   // Control field layout
   localparam int BDU_CTL_LOCK_BIT = 13;
   localparam int BDU_CTL_TYPE_LSB = 16;
   localparam int BDU_CTL_SLOT_STRIDE = 4;
   localparam logic [31:0] BDU_CTL_FIXED_ONES = 32'h0000_0400;
   localparam logic [31:0] BDU_CTL_WRITABLE = 32'hFFFF_20FF;
   // Status field layout
   localparam int BDU_STS_TASK_BIT = 15;
   localparam int BDU_STS_STEP_BIT = 14;
   // Values after reset
   localparam logic [31:0] BDU_CTL_RESET = 32'h0000_0400;
   localparam logic [31:0] BDU_STS_RESET = 32'h0000_0000;
   localparam logic [31:0] BDU_ADDR_RESET = 32'h0000_0000;
   // Access type and length codes
   localparam logic [1:0] BDU_TYPE_EXEC = 2'h0;
   localparam logic [1:0] BDU_TYPE_WRITE = 2'h1;
   localparam logic [1:0] BDU_TYPE_RDWR = 2'h3;
   localparam logic [1:0] BDU_LEN_1 = 2'h0;
   localparam logic [1:0] BDU_LEN_2 = 2'h1;
   localparam logic [1:0] BDU_LEN_4 = 2'h3;
   localparam int BDU_STEP_TRAP_FLAG_BIT = 8;
   typedef struct packed {
      logic [BDU_SLOTS-1:0][31:0] slot_addr;
      logic [31:0] ctl;
      logic [31:0] sts;
      logic [31:0] rdata;
      logic rvalid;
      logic lock_fault;
      logic exc;
   } bdu_state_t;
endpackage : bdu_pkg

// File: src/bdu_breakpoint_unit.sv
// Notes on behaviour
// - Type field: 00 execute, 01 data write, 11 read or write; 10 unused.
// - Length field: 00 one byte, 01 two bytes, 11 four bytes; 10 unused.
// - Global enable arms slot for all tasks; task switch leaves it alone.
// - Local enable arms slot for this task; cleared on every task switch.
// - Lock bit set blocks all debug register accesses.
// - Lock bit clears whenever any debug exception is taken.
// - At exception, every matching slot flags, enabled or not.
// - Task-switch flag set when switching to a trap-marked task.
// - Single-step flag set when exception came from step trap flag.
// - Four slots hold linear addresses compared by type and length.
// - Execute breakpoint fires before the matching instruction runs.
// - Status never self-clears; software writes it to clear.
`timescale 1ns/1ns
`default_nettype none
module bdu_breakpoint_unit
   import bdu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_sel,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_lock_fault,
   input wire logic acc_valid,
   input wire logic acc_fetch,
   input wire logic acc_write,
   input wire logic [31:0] acc_addr,
   input wire logic [2:0] acc_size,
   input wire logic task_switch,
   input wire logic task_trap,
   input wire logic step_done,
   input wire logic [31:0] core_flags,
   output logic debug_exc
);
   bdu_state_t s_q, s_d;
   logic [BDU_SLOTS-1:0] hit;
   logic [BDU_SLOTS-1:0] armed;
   logic step_hit;

   genvar g;
   generate
      for (g = 0; g < BDU_SLOTS; g++) begin : g_slot
         logic [1:0] ty;
         logic [1:0] ln;
         logic [31:0] mask;
         logic [31:0] lo;
         logic [31:0] hi;
         logic type_ok;
         assign ty = s_q.ctl[BDU_CTL_TYPE_LSB + g*BDU_CTL_SLOT_STRIDE +: 2];
         assign ln = s_q.ctl[BDU_CTL_TYPE_LSB + g*BDU_CTL_SLOT_STRIDE + 2 +: 2];
         // Watched region is aligned to its own size
         assign mask = (ln == BDU_LEN_4) ? 32'hFFFF_FFFC :
                       (ln == BDU_LEN_2) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
         assign type_ok = (ty == BDU_TYPE_EXEC) ? acc_fetch :
                          (ty == BDU_TYPE_WRITE) ? (!acc_fetch && acc_write) :
                          (ty == BDU_TYPE_RDWR) ? !acc_fetch : 1'b0;
         assign lo = acc_addr;
         assign hi = acc_addr + {29'h0, acc_size} - 32'h1;
         // The first or the last byte of the access inside the watched region counts
         assign hit[g] = acc_valid && type_ok && (ln != 2'h2) &&
            (((lo & mask) == (s_q.slot_addr[g] & mask)) ||
             ((hi & mask) == (s_q.slot_addr[g] & mask)));
         assign armed[g] = s_q.ctl[2*g] || s_q.ctl[2*g+1];
      end
   endgenerate

   assign step_hit = step_done && core_flags[BDU_STEP_TRAP_FLAG_BIT];

   always_comb begin
      logic fire;
      logic [31:0] rd;
      fire = 1'b0;
      rd = 32'h0000_0000;
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.lock_fault = 1'b0;
      // Fetch hit is flagged before the instruction retires
      fire = (|(hit & armed)) || step_hit;
      s_d.exc = fire;
      // Register moves; the lock refuses every one of them
      if ((reg_wr || reg_rd) && s_q.ctl[BDU_CTL_LOCK_BIT]) begin
         s_d.lock_fault = 1'b1;
      end else if (reg_wr) begin
         case (reg_sel)
            BDU_SEL_SLOT0, BDU_SEL_SLOT1, BDU_SEL_SLOT2, BDU_SEL_SLOT3: begin
               s_d.slot_addr[reg_sel[1:0]] = reg_wdata;
            end
            BDU_SEL_STATUS: begin
               s_d.sts = reg_wdata & {16'h0, 1'b1, 1'b1, 10'h0, 4'hF};
            end
            BDU_SEL_CONTROL: begin
               s_d.ctl = (reg_wdata & BDU_CTL_WRITABLE) | BDU_CTL_FIXED_ONES;
            end
            default: begin
            end
         endcase
      end else if (reg_rd) begin
         case (reg_sel)
            BDU_SEL_SLOT0, BDU_SEL_SLOT1, BDU_SEL_SLOT2, BDU_SEL_SLOT3: begin
               rd = s_q.slot_addr[reg_sel[1:0]];
            end
            BDU_SEL_STATUS: rd = s_q.sts;
            BDU_SEL_CONTROL: rd = s_q.ctl;
            default: rd = 32'h0000_0000;
         endcase
         s_d.rdata = rd;
         s_d.rvalid = 1'b1;
      end
      // Local enables drop on a task switch, globals stay
      if (task_switch) begin
         for (int i = 0; i < BDU_SLOTS; i++) begin
            s_d.ctl[2*i] = 1'b0;
         end
         if (task_trap) begin
            s_d.sts[BDU_STS_TASK_BIT] = 1'b1;
         end
      end
      // Hardware sets override a same-cycle software clear
      if (fire) begin
         s_d.ctl[BDU_CTL_LOCK_BIT] = 1'b0;
         for (int i = 0; i < BDU_SLOTS; i++) begin
            if (hit[i]) begin
               s_d.sts[i] = 1'b1;
            end
         end
         if (step_hit) begin
            s_d.sts[BDU_STS_STEP_BIT] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.slot_addr <= {BDU_SLOTS{BDU_ADDR_RESET}};
         s_q.ctl <= BDU_CTL_RESET;
         s_q.sts <= BDU_STS_RESET;
         s_q.rdata <= 32'h0000_0000;
         s_q.rvalid <= 1'b0;
         s_q.lock_fault <= 1'b0;
         s_q.exc <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign reg_rvalid = s_q.rvalid;
   assign reg_lock_fault = s_q.lock_fault;
   assign debug_exc = s_q.exc;
endmodule : bdu_breakpoint_unit
`default_nettype wire

// File: test/bdu_props.sv
`timescale 1ns/1ns
`default_nettype none
module bdu_chk
   import bdu_pkg::*;
(input wire logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, reg_lock_fault,
   input wire logic acc_valid, step_done, debug_exc,
   input wire logic [2:0] reg_sel,
   input wire logic [31:0] reg_wdata, core_flags);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_disarm;
      reg_wr && reg_sel == BDU_SEL_CONTROL && reg_wdata[7:0] == 8'h00;
   endsequence
   sequence s_quiet; !reg_lock_fault && !step_done && !reg_wr; endsequence
   property p_disarm; s_disarm ##1 s_quiet |=> !debug_exc; endproperty
   a_disarm: assert property (p_disarm) else $error("exc unarmed");
   property p_step;
      step_done && core_flags[BDU_STEP_TRAP_FLAG_BIT] |=> debug_exc;
   endproperty
   a_step: assert property (p_step) else $error("step no exc");
   property p_cause; debug_exc |-> $past(acc_valid || step_done); endproperty
   a_cause: assert property (p_cause) else $error("exc no cause");
   property p_ans; reg_rd && !reg_wr |=> reg_rvalid ^ reg_lock_fault; endproperty
   a_ans: assert property (p_ans) else $error("read unanswered");
   property p_lf; reg_lock_fault |-> $past(reg_rd || reg_wr); endproperty
   a_lf: assert property (p_lf) else $error("stray fault");
   property p_rv; reg_rvalid |-> $past(reg_rd && !reg_wr); endproperty
   a_rv: assert property (p_rv) else $error("stray rvalid");
   property p_wr; reg_wr |=> !reg_rvalid; endproperty
   a_wr: assert property (p_wr) else $error("write gave data");
   property p_unlock; debug_exc && reg_rd |=> !reg_lock_fault; endproperty
   a_unlock: assert property (p_unlock) else $error("lock kept");
endmodule : bdu_chk
bind bdu_breakpoint_unit bdu_chk u_chk(.clk, .rst_n, .reg_wr, .reg_rd,
   .reg_rvalid, .reg_lock_fault, .acc_valid, .step_done, .debug_exc,
   .reg_sel, .reg_wdata, .core_flags);
`default_nettype wire

// File: test/bdu_core.sv
`timescale 1ns/1ns
`default_nettype none
module bdu_core(input wire logic clk, output logic acc_valid, acc_fetch,
   output logic acc_write, task_switch, task_trap, step_done,
   output logic [31:0] acc_addr, core_flags, output logic [2:0] acc_size);
   initial {acc_valid, acc_fetch, acc_write, task_switch, task_trap,
      step_done, acc_addr, core_flags, acc_size} = '0;
   // Kind bits: valid, fetch, write, switch, trap, step
   task automatic go(input logic [5:0] k, input logic [31:0] a,
      input logic [2:0] s);
      @(negedge clk);
      {acc_valid, acc_fetch, acc_write, task_switch, task_trap, step_done} = k;
      {acc_addr, acc_size, core_flags} = {a, s, 23'h0, k[0], 8'h00};
      @(negedge clk);
      {acc_valid, acc_fetch, acc_write, task_switch, task_trap, step_done} = '0;
      // Idle address inverted so a stale value never matches by luck
      {acc_addr, acc_size, core_flags} = {~a, ~s, 32'h0};
   endtask : go
endmodule : bdu_core
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
   import bdu_pkg::*;
;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
   logic [2:0] reg_sel = '0, acc_size;
   logic [31:0] reg_wdata = '0, reg_rdata, acc_addr, core_flags;
   logic reg_lock_fault, debug_exc, acc_valid, acc_fetch, acc_write;
   logic task_switch, task_trap, step_done;
   int miscompares = 0, n_checks = 0;
   always #2 clk = ~clk;
   bdu_breakpoint_unit u_dut(.*);
   bdu_core u_core(.*);
   task automatic conclude();
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic mv(input logic w, input logic [2:0] s, input logic [31:0] d);
      @(negedge clk);
      {reg_wr, reg_rd, reg_sel, reg_wdata} = {w, !w, s, d};
      @(negedge clk);
      {reg_wr, reg_rd} = '0;
   endtask : mv
   task automatic rd(input logic [2:0] s, input logic [31:0] e);
      mv(1'h0, s, 32'h0);
      chk({30'h0, reg_lock_fault, reg_rvalid}, 32'h1);
      chk(reg_rdata, e);
   endtask : rd
   task automatic hit(input logic [5:0] k, input logic [31:0] a, input logic e);
      u_core.go(k, a, 3'h1);
      chk({31'h0, debug_exc}, {31'h0, e});
   endtask : hit
   task automatic t_types();
      logic [5:0] kk;
      mv(1'h1, BDU_SEL_SLOT0, 32'h100);
      for (int i = 0; i < 3; i++) begin
         // Length codes 0,1,3 pair with types 0,1,3 here
         mv(1'h1, BDU_SEL_CONTROL, 32'h401 | (32'(i + i / 2) * 32'h5_0000));
         hit(6'h30, 32'h100, i == 0);
         hit(6'h28, 32'h100, i > 0);
         hit(6'h20, 32'h100, i == 2);
         kk = i == 0 ? 6'h30 : i == 1 ? 6'h28 : 6'h20;
         hit(kk, 32'h100 + (1 << i) - 1, 1'h1);
         hit(kk, 32'h100 + (1 << i), 1'h0);
      end
   endtask : t_types
   task automatic t_status();
      mv(1'h1, BDU_SEL_SLOT1, 32'h100);
      mv(1'h1, BDU_SEL_CONTROL, 32'h00FF_0401);
      mv(1'h1, BDU_SEL_STATUS, 32'h0);
      hit(6'h20, 32'h102, 1'h1);
      rd(BDU_SEL_STATUS, 32'h3);
      mv(1'h1, BDU_SEL_CONTROL, 32'h00FF_2401);
      mv(1'h1, BDU_SEL_SLOT0, 32'h200);
      chk({31'h0, reg_lock_fault}, 32'h1);
      mv(1'h0, BDU_SEL_CONTROL, 32'h0);
      chk({30'h0, reg_lock_fault, reg_rvalid}, 32'h2);
      fork
         hit(6'h01, 32'h0, 1'h1);
         begin @(negedge clk); rd(BDU_SEL_CONTROL, 32'h00FF_0401); end
      join
      rd(BDU_SEL_SLOT0, 32'h100);
      rd(BDU_SEL_STATUS, 32'h4003);
   endtask : t_status
   task automatic t_task();
      mv(1'h1, BDU_SEL_CONTROL, 32'h0000_04FF);
      hit(6'h06, 32'h0, 1'h0);
      rd(BDU_SEL_CONTROL, 32'h0000_04AA);
      rd(BDU_SEL_STATUS, 32'hC003);
      mv(1'h1, BDU_SEL_CONTROL, 32'h400);
      hit(6'h30, 32'h100, 1'h0);
      rd(BDU_SEL_STATUS, 32'hC003);
   endtask : t_task
   initial begin
      #20000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      rd(BDU_SEL_CONTROL, BDU_CTL_RESET);
      rd(3'h4, 32'h0);
      t_types();
      t_status();
      t_task();
      conclude();
   end
endmodule : testbench
`default_nettype wire
